// ### eeprom_cmd_pkg.sv
package eeprom_cmd_pkg;
    localparam logic [3:0] cmd_upper_zero = 4'h0;
    localparam logic [2:0] cmd_write_enable = 3'h6;
    localparam logic [2:0] cmd_write_disable = 3'h4;
    localparam logic [2:0] cmd_read_status = 3'h5;
    localparam logic [2:0] cmd_write_status = 3'h1;
    localparam logic [2:0] cmd_array_read = 3'h3;
    localparam logic [2:0] cmd_array_write = 3'h2;
    localparam int protect_enable_pos = 7;
    localparam int block_protect_hi_pos = 3;
    localparam int block_protect_lo_pos = 2;
    localparam int write_latch_pos = 1;
    localparam int busy_pos = 0;
    localparam logic [2:0] reserved_busy_value = 3'h7;
    localparam logic [2:0] reserved_idle_value = 3'h0;
    localparam logic [2:0] nv_reset_value = 3'h0;
    localparam logic [2:0] bit_count_last = 3'h7;
    localparam int write_cycle_ns = 5000000;
    localparam int clk_period_ns = 25;
    localparam int write_cycle_cycles = write_cycle_ns / clk_period_ns;
    localparam logic [17:0] write_cycle_last = 18'(write_cycle_cycles - 1);
endpackage

// ### spi_eeprom_command_status.sv
`timescale 1ns/1ps
// Function
// R01: a transaction starts at chip select falling; bytes arrive msb first, 8-bit opcode.
// R02: write enable x110, write disable x100, read status x101; bit 3 ignored.
// R03: write status x001, array read x011, array write x010; bit 3 ignored.
// R04: status holds protect enable b7, block protect b3:2, write latch b1, busy b0.
// R05: bits 6:4 read zero when idle, ones during a write cycle.
// R06: busy reads 1 while an internal operation runs, else 0.
// R07: block protect field readable and writable; 00 none up to 11 entire array.
// R08: write latch is read-only, 1 when writing enabled, 0 after power-up.
// R09: after read status opcode the status byte shifts out on serial output.
// R10: host sets the write latch before each status or array write.
// R11: write enable opcode then chip select high sets the write latch.
// R12: write disable clears the write latch regardless of write protect pin.
// R13: unknown opcode ignores input, output stays off until next chip select fall.
// R14: status write changes only bits 7, 3, 2.
// R15: during a write cycle only read status works; latch clears at completion.
// R16: sample input on rising serial clock, drive output on falling edge.
module spi_eeprom_command_status #(
    parameter int write_cycle_len = eeprom_cmd_pkg::write_cycle_cycles
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_wp_n,
    output logic o_so,
    output logic o_so_oe,
    output logic [7:0] o_status,
    output logic o_array_read_start,
    output logic o_array_write_start
);
    import eeprom_cmd_pkg::*;

    typedef enum logic [2:0] {st_idle, st_opcode, st_send, st_data, st_ignore} phase_type;

    phase_type phase;
    logic cs_prev, sck_prev;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [2:0] pending;
    logic [2:0] nv_bits;
    logic [2:0] nv_new;
    logic write_latch;
    logic busy;
    logic [17:0] wc_cnt;
    logic status_write_pending;

    wire cs_fall = cs_prev & ~i_cs_n;
    wire cs_rise = ~cs_prev & i_cs_n;
    wire sck_rise = ~sck_prev & i_sck & ~i_cs_n;
    wire sck_fall = sck_prev & ~i_sck & ~i_cs_n;
    wire [7:0] opcode = {shift_in[6:0], i_si};
    wire byte_done = sck_rise && bit_cnt == bit_count_last;
    wire upper_ok = opcode[7:4] == cmd_upper_zero; // R02 R03
    wire is_set_latch = upper_ok && opcode[2:0] == cmd_write_enable; // R02
    wire is_clr_latch = upper_ok && opcode[2:0] == cmd_write_disable; // R02
    wire is_rd_status = upper_ok && opcode[2:0] == cmd_read_status; // R02
    wire is_wr_status = upper_ok && opcode[2:0] == cmd_write_status; // R03
    wire is_read = upper_ok && opcode[2:0] == cmd_array_read; // R03
    wire is_write = upper_ok && opcode[2:0] == cmd_array_write; // R03
    wire hw_protect = nv_bits[2] & ~i_wp_n;
    wire [2:0] reserved_now = busy ? reserved_busy_value : reserved_idle_value; // R05
    wire [7:0] status_now = {nv_bits[2], reserved_now, nv_bits[1:0], write_latch, busy}; // R04 R06 R07
    wire wc_done = busy && wc_cnt == 18'(write_cycle_len - 1);
    wire commit_status = cs_rise && status_write_pending && !hw_protect;
    wire [1:0] cmd_done_kind = pending[1:0];

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cs_prev <= 1'b1;
            sck_prev <= 1'b0;
        end else begin
            cs_prev <= i_cs_n;
            sck_prev <= i_sck;
        end
    end

    // opcode shifter, msb first, sampled on rising serial clock
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            phase <= st_idle;
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
            pending <= 3'h0;
            status_write_pending <= 1'b0;
            nv_new <= nv_reset_value;
            o_array_read_start <= 1'b0;
            o_array_write_start <= 1'b0;
        end else begin
            o_array_read_start <= 1'b0;
            o_array_write_start <= 1'b0;
            if (i_cs_n) begin
                phase <= st_idle;
                if (cs_rise) begin
                    pending <= 3'h0;
                    status_write_pending <= 1'b0;
                end
            end else if (cs_fall) begin // R01
                phase <= st_opcode;
                bit_cnt <= 3'h0;
                pending <= 3'h0;
                status_write_pending <= 1'b0;
            end else if (sck_rise && (phase == st_opcode || phase == st_data)) begin // R16
                shift_in <= opcode; // R01
                bit_cnt <= bit_cnt + 3'h1;
                if (byte_done && phase == st_opcode) begin
                    if (busy && !is_rd_status) begin
                        phase <= st_ignore; // R15
                    end else if (is_rd_status) begin
                        phase <= st_send; // R09
                    end else if (is_set_latch) begin
                        pending <= 3'h1; // R11
                        phase <= st_ignore;
                    end else if (is_clr_latch) begin
                        pending <= 3'h2; // R12
                        phase <= st_ignore;
                    end else if (is_wr_status && write_latch) begin // R10
                        phase <= st_data;
                    end else if (is_read) begin
                        o_array_read_start <= 1'b1;
                        phase <= st_ignore;
                    end else if (is_write && write_latch) begin
                        o_array_write_start <= 1'b1;
                        phase <= st_ignore;
                    end else begin
                        phase <= st_ignore; // R13
                    end
                end else if (byte_done && phase == st_data) begin
                    nv_new <= {opcode[protect_enable_pos], opcode[block_protect_hi_pos],
                        opcode[block_protect_lo_pos]}; // R14
                    status_write_pending <= 1'b1;
                    phase <= st_ignore;
                end
            end
        end
    end

    // status bits, write latch and the self-timed write cycle
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            nv_bits <= nv_reset_value;
            write_latch <= 1'b0; // R08
            busy <= 1'b0;
            wc_cnt <= 18'h00000;
        end else begin
            if (commit_status) begin
                nv_bits <= nv_new; // R14 R07
                busy <= 1'b1; // R06
                wc_cnt <= 18'h00000;
            end else if (wc_done) begin
                busy <= 1'b0;
                write_latch <= 1'b0; // R15
            end else if (busy) begin
                wc_cnt <= wc_cnt + 18'h00001;
            end
            if (cs_rise && cmd_done_kind == 2'h1) begin
                write_latch <= 1'b1; // R11
            end else if (cs_rise && cmd_done_kind == 2'h2) begin
                write_latch <= 1'b0; // R12
            end
        end
    end

    // serial output, changes on falling serial clock
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            shift_out <= 8'h00;
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
            o_status <= 8'h00;
        end else begin
            o_status <= status_now;
            if (i_cs_n || phase != st_send) begin
                o_so_oe <= 1'b0; // R13
                shift_out <= status_now;
            end else if (sck_fall) begin // R16
                o_so <= shift_out[7]; // R09
                o_so_oe <= 1'b1;
                shift_out <= {shift_out[6:0], shift_out[7]};
            end
        end
    end

    a_latch_set_cmd: assert property (@(posedge i_core_clk) disable iff (i_rst) // R11
        cs_rise && pending == 3'h1 |=> write_latch)
        else $error("write latch not set after write enable");
    a_latch_clear_cmd: assert property (@(posedge i_core_clk) disable iff (i_rst) // R12
        cs_rise && pending == 3'h2 |=> !write_latch)
        else $error("write latch not cleared after write disable");
    a_reserved_busy_bits: assert property (@(posedge i_core_clk) disable iff (i_rst) // R05
        o_status[6:4] == {3{o_status[0]}})
        else $error("reserved bits disagree with busy");
    a_wc_end_clears: assert property (@(posedge i_core_clk) disable iff (i_rst) // R15
        $fell(busy) |-> !write_latch)
        else $error("write latch set after write cycle");
    a_so_off_idle: assert property (@(posedge i_core_clk) disable iff (i_rst) // R13
        i_cs_n |=> !o_so_oe)
        else $error("serial output driven while deselected");
    a_so_first_msb: assert property (@(posedge i_core_clk) disable iff (i_rst) // R09
        phase == st_send && sck_fall && !o_so_oe |=> o_so == $past(shift_out[7]))
        else $error("status bit not shifted msb first");
    a_busy_ignores: assert property (@(posedge i_core_clk) disable iff (i_rst) // R15
        busy && byte_done && phase == st_opcode && !is_rd_status && !i_cs_n |=> phase == st_ignore)
        else $error("command accepted while busy");
    a_nv_only_commit: assert property (@(posedge i_core_clk) disable iff (i_rst) // R14
        !commit_status |=> $stable(nv_bits))
        else $error("protect bits changed without status write");
    a_so_off_ignore: assert property (@(posedge i_core_clk) disable iff (i_rst) // R13
        phase == st_ignore |-> !o_so_oe)
        else $error("serial output driven after refused opcode");
    a_commit_sets_busy: assert property (@(posedge i_core_clk) disable iff (i_rst) // R06
        commit_status |=> busy)
        else $error("busy not raised by status write");
    a_busy_count_bound: assert property (@(posedge i_core_clk) disable iff (i_rst) // R06
        busy |-> wc_cnt <= 18'(write_cycle_len - 1))
        else $error("write cycle counter ran past its end");
    a_start_one_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst) // R03
        o_array_read_start || o_array_write_start |=> !o_array_read_start && !o_array_write_start)
        else $error("array start pulse longer than one cycle");
endmodule

// ### spi_eeprom_command_status_tb.sv
`timescale 1ns/1ps
module spi_eeprom_command_status_tb;
    import eeprom_cmd_pkg::*;
    logic i_core_clk, i_rst, i_wp_n, cs_n, sck, si, so, so_oe;
    logic [7:0] status;
    logic [8:0] exp_q[$];
    logic [8:0] exp;
    logic [31:0] seed;
    logic [7:0] d;
    logic rd_start, wr_start;
    logic [7:0] rd_starts = 8'h00;
    logic [7:0] wr_starts = 8'h00;
    int fails, cmp_count;
    spi_eeprom_command_status #(.write_cycle_len(400)) i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe),
        .o_status(status), .o_array_read_start(rd_start), .o_array_write_start(wr_start));
    spi_host_model i_host (.i_core_clk(i_core_clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n),
        .o_sck(sck), .o_si(si));
    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic give_verdict();
        $display("mismatches %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        cmp_count++;
        if (got !== want) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, want);
        end
    endtask
    // array start pulses are counted away from the launching edge
    always @(negedge i_core_clk) begin
        if (rd_start) rd_starts <= rd_starts + 8'h01;
        if (wr_start) wr_starts <= wr_starts + 8'h01;
    end
    // answer is {output seen, last byte}; note it, then run the frame
    task automatic xfer(input logic [15:0] tx, input int n, input logic [8:0] want);
        exp_q.push_back(want);
        i_host.frame(tx, n);
    endtask
    always @(i_host.done) begin
        exp = (exp_q.size() == 0) ? 9'h1FF : exp_q.pop_front();
        cmp_count++;
        if (i_host.rx !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, i_host.rx, exp);
        end
    end
    initial begin
        repeat (100000) @(posedge i_core_clk);
        fails++;
        give_verdict();
    end
    initial begin
        i_rst = 1'b1;
        i_wp_n = 1'b1;
        seed = 32'hEE48F8FC;
        fails = 0;
        cmp_count = 0;
        repeat (20) @(posedge i_core_clk);
        #2 i_rst = 1'b0;
        xfer(16'h0500, 2, 9'h100);
        xfer(16'h0006, 1, 9'h000);
        xfer(16'h0D00, 2, 9'h102);
        i_rst = 1'b1;
        repeat (2) @(posedge i_core_clk);
        #2 i_rst = 1'b0;
        xfer(16'h0500, 2, 9'h100);
        xfer(16'h0006, 1, 9'h000);
        check(status, 8'h02);
        seed = xs(seed);
        i_wp_n = seed[0];
        xfer(16'h000C, 1, 9'h000);
        xfer(16'h0500, 2, 9'h100);
        i_wp_n = 1'b1;
        xfer(16'h0007, 1, 9'h000);
        xfer(16'hFF00, 2, 9'h000);
        xfer(16'h0003, 1, 9'h000);
        xfer(16'h0002, 1, 9'h000);
        xfer(16'h0006, 1, 9'h000);
        xfer(16'h000A, 1, 9'h000);
        check(rd_starts, 8'h01);
        check(wr_starts, 8'h01);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            d = seed[7:0] ^ {k[1:0], 6'h00};
            xfer(16'h0006, 1, 9'h000);
            xfer({8'h09, d}, 2, 9'h000);
            xfer(16'h0004, 1, 9'h000);
            xfer(16'h0500, 2, {1'b1, (d & 8'h8C) | 8'h73});
            repeat (450) @(posedge i_core_clk);
            xfer(16'h0500, 2, {1'b1, d & 8'h8C});
        end
        repeat (10) @(posedge i_core_clk);
        #2;
        check(status, d & 8'h8C);
        if (exp_q.size() != 0) fails++;
        give_verdict();
    end
endmodule

// ### spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    input wire logic i_core_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    logic [8:0] rx;
    event done;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        rx = 9'h000;
    end
    // half sck period of four core cycles, changes land just after the edge
    task automatic half();
        repeat (4) @(posedge i_core_clk);
        #2;
    endtask
    // one frame, msb first; sck stands low outside frames
    task automatic frame(input logic [15:0] tx, input int nbytes);
        logic [7:0] sh;
        logic seen;
        sh = 8'h00;
        seen = 1'b0;
        half();
        o_cs_n = 1'b0;
        for (int i = nbytes * 8 - 1; i >= 0; i--) begin
            o_si = tx[i];
            half();
            o_sck = 1'b1;
            sh = {sh[6:0], i_so};
            seen = seen | i_so_oe;
            half();
            o_sck = 1'b0;
        end
        half();
        o_cs_n = 1'b1;
        o_si = ~o_si;
        rx = seen ? {1'b1, sh} : 9'h000;
        half();
        ->done;
    endtask
endmodule
